// file: inc/pcpl_params.svh
`ifndef PCPL_PARAMS_SVH
`define PCPL_PARAMS_SVH

// Timer counts in one switching period, 200 kHz at the timer rate.
`define PCPL_PERIOD      27200
// Compare 1: the 80 percent duty limit.
`define PCPL_CMP1        21760
// Compare 2: the one sawtooth step point per period, changed at run time.
`define PCPL_CMP2        1000
// Compare 3: end of the blanking window and the sampling point.
`define PCPL_CMP3        2720
// Compare 4: the only point that turns the high side on.
`define PCPL_CMP4        1088
// Dead time in timer counts before each switch turns on.
`define PCPL_DT_RISE     75
`define PCPL_DT_FALL     300
// Sawtooth start level and decrement.
`define PCPL_SAW_RESET   4000
`define PCPL_SAW_STEP    66
// Converter input channel wired to the output voltage.
`define PCPL_ADC_CHANNEL 4
// Bits below the left-aligned conversion result.
`define PCPL_ALIGN_LSB   3

`endif

// file: inc/pcpl_pkg.sv
package pcpl_pkg;

    // Converter sequencing: wait, convert, hand the result to the stream.
    typedef enum logic [1:0] {
        PCPL_ADC_IDLE,
        PCPL_ADC_SAMPLE,
        PCPL_ADC_STORE
    } pcpl_adc_state_t;

endpackage

// file: design/pcpl_word_buffer.sv
`timescale 1ns/1ps

// Small FIFO whose head entry is a register, so the read data leave a flop.
module pcpl_word_buffer #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
) (
    input  logic             mclk,
    input  logic             nrst,
    input  logic             ce,
    input  logic             inValid,
    output logic             inReady,
    input  logic [WIDTH-1:0] inData,
    output logic             outValid,
    input  logic             outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];  // Entry 0 is the head.
    logic [CW-1:0]    count_reg;        // Number of words held.
    logic [CW-1:0]    count_next;       // Word count after this cycle.
    logic             valid_reg;        // Head holds a word.
    logic             push;             // Word accepted this cycle.
    logic             pop;              // Word delivered this cycle.
    logic [CW-1:0]    wrIdx;            // Slot the incoming word lands in.

    // Ready drops when full, which stalls the converter sequencer.
    assign inReady  = count_reg != CW'(DEPTH);
    assign push     = inValid && inReady && ce;
    assign pop      = valid_reg && outReady && ce;
    assign outValid = valid_reg;
    assign outData  = mem_reg[0];

    // A pop shifts every word down, so the write slot moves down one too.
    always_comb begin
        count_next = count_reg + CW'(push) - CW'(pop);
        wrIdx      = pop ? count_reg - 1'b1 : count_reg;
    end

    // Occupancy and the registered valid flag.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count_reg <= '0;
            valid_reg <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            valid_reg <= count_next != '0;
        end
    end

    // Storage shifts toward the head; the later write wins its slot.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                if (pop) begin
                    mem_reg[i] <= mem_reg[i+1];
                end
            end
            for (int i = 0; i < DEPTH; i++) begin
                if (push && wrIdx == CW'(i)) begin
                    mem_reg[i] <= inData;
                end
            end
        end
    end

endmodule

// file: design/pcpl_loop.sv
`timescale 1ns/1ps
`include "pcpl_params.svh"

// Operation
// - Each conversion result streams to the filter.
// - Endless word transfers from one fixed address.
// - Result left-aligned in sixteen bits with sign.
// - Convert only on trigger; no converter interrupt.
// - One conversion per trigger on channel four.
// - Stored value is setpoint minus measured voltage.
// - Threshold stays internal; triggers from output three.
// - Decrementing sawtooth, 4000 start, step 66.
// - Current reaching threshold ends the on-time.
// - Observed comparator pin is inverted.
// - Comparator feeds the timer as event three.
// - Period of 27200 counts, 200 kHz.
// - Complementary pair with dead time, never overlapping.
// - Compare 1 at 21760 turns high side off.
// - Compare 2 steps the sawtooth, run-time value.
// - Boost switch drives held at static levels.
// - Compare 3 ends blanking and triggers conversion.
// - Compare 4 alone turns the high side on.
// - Two off sources; dead times 75 and 300.
// - Sawtooth reloads each period, steps on compare 2.
module pcpl_loop
    import pcpl_pkg::*;
#(
    parameter int unsigned CW      = 15,
    parameter int unsigned PERIOD  = `PCPL_PERIOD,
    parameter int unsigned CMP1    = `PCPL_CMP1,
    parameter int unsigned CMP3    = `PCPL_CMP3,
    parameter int unsigned CMP4    = `PCPL_CMP4,
    parameter int unsigned DT_RISE = `PCPL_DT_RISE,
    parameter int unsigned DT_FALL = `PCPL_DT_FALL
) (
    input  logic          mclk,
    input  logic          nrst,
    input  logic          ce,
    input  logic [11:0]   adcSample,        // Level on the voltage channel.
    input  logic [11:0]   setpoint,         // Offset the converter subtracts the sample from.
    input  logic [11:0]   currentSense,     // Inductor current, from a pin.
    input  logic          filtOutValid,     // Filter produced a new threshold.
    input  logic [11:0]   filtOut,
    input  logic          sawWrite,         // Software rewrites sawtooth values.
    input  logic [11:0]   sawResetIn,
    input  logic [11:0]   sawStepIn,
    input  logic          cmp2Write,        // Software moves compare 2.
    input  logic [CW-1:0] cmp2In,
    input  logic          boostHighLevel,
    input  logic          boostLowLevel,
    input  logic          filtReady,
    output logic          highSideDrive,
    output logic          lowSideDrive,
    output logic          boostHighDrive,
    output logic          boostLowDrive,
    output logic          comparatorObservePin,
    output logic          dacBufferEnable,
    output logic          adcIrq,
    output logic [2:0]    adcChannel,
    output logic [11:0]   thresholdLevel,
    output logic          filtValid,
    output logic [31:0]   filtData,
    output logic          resultOverrun
);

    localparam logic [CW-1:0] PER_M1 = CW'(PERIOD - 1);
    localparam logic [CW-1:0] CMP1_C = CW'(CMP1);
    localparam logic [CW-1:0] CMP3_C = CW'(CMP3);
    localparam logic [CW-1:0] CMP4_C = CW'(CMP4);
    localparam logic [8:0]    DTR_M1 = 9'(DT_RISE - 1);
    localparam logic [8:0]    DTF_M1 = 9'(DT_FALL - 1);

    // Left-aligned signed error: setpoint minus sample, low bits zero.
    function automatic logic [15:0] pcplAlign(input logic [11:0] sp,
                                              input logic [11:0] smp);
        logic [12:0] diff;
        diff = {1'b0, sp} - {1'b0, smp};
        return {diff, {`PCPL_ALIGN_LSB{1'b0}}};
    endfunction

    // Decrement that stops at zero instead of wrapping to full scale.
    function automatic logic [11:0] pcplStep(input logic [11:0] lvl,
                                             input logic [11:0] stp);
        return (lvl > stp) ? lvl - stp : 12'h000;
    endfunction

    logic [CW-1:0]   cnt_reg;        // Timer counter.
    logic [CW-1:0]   cmp2_reg;       // Sawtooth step compare.
    logic            periodStart;    // Counter reset or roll-over.
    logic            cmp1Hit;
    logic            cmp2Hit;
    logic            cmp3Hit;
    logic            cmp4Hit;
    logic [11:0]     sense1_reg;     // Pin synchroniser stages.
    logic [11:0]     sense2_reg;
    logic [11:0]     sense3_reg;
    logic [11:0]     senseAcc_reg;   // Current level taken once stable.
    logic            cmpOut_reg;     // Internal comparison result.
    logic            obs_reg;        // Observation pin level.
    logic            extEvent;       // Event three after blanking.
    logic            hsRef_reg;      // High-side demand before dead time.
    logic            hsPrev_reg;     // Demand one cycle ago.
    logic [8:0]      dtCnt_reg;      // Dead-time counter.
    logic            hsOut_reg;
    logic            lsOut_reg;
    pcpl_adc_state_t adcState_reg;
    logic [11:0]     sampleHold_reg; // Sample captured at the trigger.
    logic [15:0]     result_reg;     // Converter result register.
    logic            overrun_reg;    // A trigger found the converter busy.
    logic            bufReady;
    logic [11:0]     resetVal_reg;   // Sawtooth start for next period.
    logic [11:0]     stepVal_reg;    // Sawtooth decrement.
    logic [11:0]     dac_reg;        // Threshold level.
    logic            boostHigh_reg;
    logic            boostLow_reg;
    logic            dacBufEn_reg;
    logic            adcIrq_reg;
    logic [2:0]      adcCh_reg;

    // Timer period counter wraps after the last count.
    // period count
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_reg <= '0;
        end else if (ce) begin
            cnt_reg <= (cnt_reg == PER_M1) ? '0 : cnt_reg + 1'b1;
        end
    end

    // Compare 2 moves at run time; the others are fixed.
    // run-time compare
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmp2_reg <= CW'(`PCPL_CMP2);
        end else if (ce && cmp2Write) begin
            cmp2_reg <= cmp2In;
        end
    end

    assign periodStart = cnt_reg == '0;
    assign cmp1Hit     = cnt_reg == CMP1_C;
    assign cmp2Hit     = cnt_reg == cmp2_reg;
    assign cmp3Hit     = cnt_reg == CMP3_C;
    assign cmp4Hit     = cnt_reg == CMP4_C;

    // Three stages on the asynchronous current input; a new level is taken
    // only once the last two stages agree, so a word caught mid-change
    // never reaches the comparator.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sense1_reg   <= '0;
            sense2_reg   <= '0;
            sense3_reg   <= '0;
            senseAcc_reg <= '0;
        end else if (ce) begin
            sense1_reg <= currentSense;
            sense2_reg <= sense1_reg;
            sense3_reg <= sense2_reg;
            if (sense2_reg == sense3_reg) begin
                senseAcc_reg <= sense3_reg;
            end
        end
    end

    // Current on the plus side against the threshold on the minus side.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmpOut_reg <= 1'b0;
            obs_reg    <= 1'b1;
        end else if (ce) begin
            cmpOut_reg <= senseAcc_reg >= dac_reg;
            obs_reg    <= !(senseAcc_reg >= dac_reg);
        end
    end

    // Comparator events before compare 3 are ignored, which hides the
    // switching spike that follows the high side turning on.
    // blanking window
    assign extEvent = cmpOut_reg && (cnt_reg >= CMP3_C);

    // High-side demand: one set source, two reset sources; reset wins.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hsRef_reg <= 1'b0;
        end else if (ce) begin
            if (cmp1Hit || extEvent) begin
                hsRef_reg <= 1'b0;
            end else if (cmp4Hit) begin
                hsRef_reg <= 1'b1;
            end
        end
    end

    // Dead-time insertion: a switch turns off at once and the other turns
    // on only after its delay, so the pair can never overlap.
    // dead-time pair
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hsPrev_reg <= 1'b0;
            dtCnt_reg  <= '0;
            hsOut_reg  <= 1'b0;
            lsOut_reg  <= 1'b0;
        end else if (ce) begin
            hsPrev_reg <= hsRef_reg;
            if (hsRef_reg != hsPrev_reg) begin
                // Demand changed; restart the delay and drop both.
                dtCnt_reg <= '0;
                hsOut_reg <= 1'b0;
                lsOut_reg <= 1'b0;
            end else if (hsRef_reg && !hsOut_reg) begin
                if (dtCnt_reg == DTR_M1) begin
                    hsOut_reg <= 1'b1;
                end else begin
                    dtCnt_reg <= dtCnt_reg + 1'b1;
                end
            end else if (!hsRef_reg && !lsOut_reg) begin
                if (dtCnt_reg == DTF_M1) begin
                    lsOut_reg <= 1'b1;
                end else begin
                    dtCnt_reg <= dtCnt_reg + 1'b1;
                end
            end
        end
    end

    // Converter sequencer. A trigger while busy is dropped and flagged;
    // the limitation is that a stalled stream costs samples, not order.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adcState_reg   <= PCPL_ADC_IDLE;
            sampleHold_reg <= '0;
            result_reg     <= '0;
            overrun_reg    <= 1'b0;
        end else if (ce) begin
            unique case (adcState_reg)
                PCPL_ADC_IDLE: begin
                    if (cmp3Hit) begin
                        sampleHold_reg <= adcSample;
                        adcState_reg   <= PCPL_ADC_SAMPLE;
                    end
                end
                PCPL_ADC_SAMPLE: begin
                    result_reg   <= pcplAlign(setpoint, sampleHold_reg);
                    adcState_reg <= PCPL_ADC_STORE;
                end
                PCPL_ADC_STORE: begin
                    // Hold the request until the buffer takes the word.
                    if (bufReady) begin
                        adcState_reg <= PCPL_ADC_IDLE;
                    end
                end
                default: begin
                    adcState_reg <= PCPL_ADC_IDLE;
                end
            endcase
            if (cmp3Hit && adcState_reg != PCPL_ADC_IDLE) begin
                overrun_reg <= 1'b1;
            end
        end
    end

    // Stream path to the filter: every result, one word each, forever.
    // result streaming
    pcpl_word_buffer #(
        .WIDTH (32),
        .DEPTH (2)
    ) u_buffer (
        .mclk     (mclk),
        .nrst     (nrst),
        .ce       (ce),
        .inValid  (adcState_reg == PCPL_ADC_STORE),
        .inReady  (bufReady),
        .inData   ({16'h0000, result_reg}),
        .outValid (filtValid),
        .outReady (filtReady),
        .outData  (filtData)
    );

    // Sawtooth start and step; a software write beats a filter result.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resetVal_reg <= 12'(`PCPL_SAW_RESET);
            stepVal_reg  <= 12'(`PCPL_SAW_STEP);
        end else if (ce) begin
            if (sawWrite) begin
                resetVal_reg <= sawResetIn;
                stepVal_reg  <= sawStepIn;
            end else if (filtOutValid) begin
                resetVal_reg <= filtOut;
            end
        end
    end

    // Threshold sawtooth: reload at period start, else step down on compare 2.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dac_reg <= 12'(`PCPL_SAW_RESET);
        end else if (ce) begin
            if (periodStart) begin
                dac_reg <= resetVal_reg;
            end else if (cmp2Hit) begin
                dac_reg <= pcplStep(dac_reg, stepVal_reg);
            end
        end
    end

    // Static configuration: boost levels, internal-only threshold, no
    // converter interrupt, fixed channel.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            boostHigh_reg <= 1'b0;
            boostLow_reg  <= 1'b0;
            dacBufEn_reg  <= 1'b0;
            adcIrq_reg    <= 1'b0;
            adcCh_reg     <= 3'(`PCPL_ADC_CHANNEL);
        end else if (ce) begin
            boostHigh_reg <= boostHighLevel;
            boostLow_reg  <= boostLowLevel;
            dacBufEn_reg  <= 1'b0;
            adcIrq_reg    <= 1'b0;
        end
    end

    assign highSideDrive        = hsOut_reg;
    assign lowSideDrive         = lsOut_reg;
    assign boostHighDrive       = boostHigh_reg;
    assign boostLowDrive        = boostLow_reg;
    assign comparatorObservePin = obs_reg;
    assign dacBufferEnable      = dacBufEn_reg;
    assign adcIrq               = adcIrq_reg;
    assign adcChannel           = adcCh_reg;
    assign thresholdLevel       = dac_reg;
    assign resultOverrun        = overrun_reg;

    // Helper: enabled cycles with both switches off, for dead-time checks.
    logic [9:0] gap_reg;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gap_reg <= '0;
        end else if (ce) begin
            gap_reg <= (!hsOut_reg && !lsOut_reg) ? gap_reg + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence trigIdle;
        ce && cmp3Hit && adcState_reg == PCPL_ADC_IDLE;
    endsequence
    sequence convStep;
        ce && adcState_reg == PCPL_ADC_SAMPLE;
    endsequence

    period_wrap_a: assert property (ce && cnt_reg == PER_M1 |=> cnt_reg == '0)
        else $error("Timer did not wrap at the period end.");
    hs_set_a: assert property (ce && cmp4Hit && !cmp1Hit && !extEvent |=> hsRef_reg)
        else $error("Compare 4 did not set the high side.");
    hs_limit_a: assert property (ce && cmp1Hit |=> !hsRef_reg)
        else $error("Compare 1 did not clear the high side.");
    peak_reset_a: assert property (ce && extEvent |=> !hsRef_reg)
        else $error("Comparator event did not clear the high side.");
    blank_window_a: assert property (ce && hsRef_reg && cnt_reg < CMP3_C |=>
        hsRef_reg)
        else $error("High side cleared inside blanking.");
    no_overlap_a: assert property (!(hsOut_reg && lsOut_reg))
        else $error("Both switches driven at once.");
    dead_rise_a: assert property ($rose(hsOut_reg) |-> gap_reg == 10'(DT_RISE))
        else $error("Rising dead time wrong.");
    dead_fall_a: assert property ($rose(lsOut_reg) |-> gap_reg >= 10'(DT_FALL))
        else $error("Falling dead time too short.");
    adc_start_a: assert property (trigIdle ##1 convStep |=>
        adcState_reg == PCPL_ADC_STORE)
        else $error("Trigger did not lead to a stored result.");
    error_calc_a: assert property (convStep |=>
        result_reg == pcplAlign($past(setpoint), $past(sampleHold_reg)))
        else $error("Stored result is not setpoint minus sample.");
    saw_reload_a: assert property (ce && periodStart |=>
        dac_reg == $past(resetVal_reg))
        else $error("Sawtooth did not reload at period start.");
    saw_step_a: assert property (ce && cmp2Hit && !periodStart |=>
        dac_reg == pcplStep($past(dac_reg), $past(stepVal_reg)))
        else $error("Sawtooth did not step on compare 2.");
    obs_invert_a: assert property (ce |=>
        obs_reg == ($past(senseAcc_reg) < $past(dac_reg)))
        else $error("Observation pin not inverted.");
    dma_word_a: assert property (adcState_reg == PCPL_ADC_STORE && !bufReady
        && ce |=> adcState_reg == PCPL_ADC_STORE)
        else $error("Result dropped while the stream stalled.");

endmodule

// file: tb/pcpl_buck_stage.sv
`timescale 1ns/1ps

// Behavioural buck stage: the inductor current ramps up while the high
// side conducts and falls towards the load floor otherwise.
module pcpl_buck_stage (
    input  logic        mclk,
    input  logic        highSideDrive,
    input  logic [11:0] slope,
    input  logic [11:0] floorLevel,
    output logic [11:0] currentSense
);
    logic [12:0] curReg;  // Spare bit catches overflow before clamping.
    logic        stepPh;  // High on the clocks at which the current moves.

    // The current moves every other clock: the block takes a sense word only
    // once two synchroniser stages agree, so a word that changed every clock
    // would never be taken.
    always @(posedge mclk) begin
        stepPh <= (stepPh === 1'b1) ? 1'b0 : 1'b1;
        if (curReg === 13'bx) begin
            curReg <= 13'h0;
        end else if (stepPh !== 1'b1) begin
            curReg <= curReg;
        end else if (highSideDrive) begin
            curReg <= (curReg + slope > 13'hfff) ? 13'hfff : curReg + slope;
        end else if (curReg < floorLevel + slope) begin
            curReg <= {1'b0, floorLevel};
        end else begin
            curReg <= curReg - slope;
        end
    end
    assign currentSense = curReg[11:0];
endmodule

// file: tb/tb_pcpl_loop.sv
`timescale 1ns/1ps

// Closed-loop bench: the buck model closes the current loop around dut.
module tb_pcpl_loop;
    localparam int PER = 400;  // Shortened period keeps the run brief.
    localparam int C1  = 320;
    localparam int C3  = 40;
    localparam int C4  = 16;
    localparam int DR  = 3;
    localparam int DF  = 5;
    logic        mclk, nrst, ce, filtOutValid, sawWrite, cmp2Write, filtReady;
    logic        boostHighLevel, boostLowLevel, highSideDrive, lowSideDrive;
    logic        boostHighDrive, boostLowDrive, comparatorObservePin;
    logic        dacBufferEnable, adcIrq, filtValid, resultOverrun;
    logic [2:0]  adcChannel;
    logic [11:0] adcSample, setpoint, currentSense, filtOut, sawResetIn, sawStepIn;
    logic [11:0] thresholdLevel, slope, floorLevel;
    logic [12:0] diff;
    logic [14:0] cmp2In;
    logic [31:0] filtData;
    int          errCount, nCompared, w, k;

    pcpl_loop #(.PERIOD(PER), .CMP1(C1), .CMP3(C3), .CMP4(C4), .DT_RISE(DR),
        .DT_FALL(DF)) dut (.mclk, .nrst, .ce, .adcSample, .setpoint, .currentSense,
        .filtOutValid, .filtOut, .sawWrite, .sawResetIn, .sawStepIn, .cmp2Write,
        .cmp2In, .boostHighLevel, .boostLowLevel, .filtReady, .highSideDrive,
        .lowSideDrive, .boostHighDrive, .boostLowDrive, .comparatorObservePin,
        .dacBufferEnable, .adcIrq, .adcChannel, .thresholdLevel, .filtValid,
        .filtData, .resultOverrun);
    pcpl_buck_stage buck (.mclk, .highSideDrive, .slope, .floorLevel, .currentSense);

    // Compares one value and counts it; a mismatch is printed at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Waits, bounded, for the high side to reach a level.
    task automatic wait_hs(input logic lvl);
        repeat (2000) if (highSideDrive !== lvl) @(negedge mclk);
    endtask

    // Measures one fresh high-side on-time in clocks.
    task automatic on_width;
        wait_hs(1'b0);
        wait_hs(1'b1);
        for (w = 0; highSideDrive === 1'b1 && w < 2000; w++) @(negedge mclk);
    endtask

    task automatic saw_load(input logic [11:0] r, input logic [11:0] s);
        @(posedge mclk);
        sawResetIn <= r;
        sawStepIn <= s;
        sawWrite <= 1'b1;
        @(posedge mclk);
        sawWrite <= 1'b0;
    endtask

    // Waits for the next threshold change and judges the new level.
    task automatic next_thr(input logic [11:0] exp);
        logic [11:0] old;
        old = thresholdLevel;
        repeat (2 * PER) if (thresholdLevel === old) @(negedge mclk);
        check(32'(thresholdLevel), 32'(exp));
    endtask

    task automatic t_reset;
        check(32'({highSideDrive, lowSideDrive, comparatorObservePin}), 32'h1);
        check(32'(thresholdLevel), 32'd4000);
        check(32'({dacBufferEnable, adcIrq, filtValid}), 32'h0);
        check(32'(adcChannel), 32'h4);
    endtask

    // Slow current never trips, so compare 1 ends each on-time.
    task automatic t_dead;
        on_width;
        check(32'(w >= C1 - C4 - DR - 1 && w <= C1 - C4 - DR + 4), 32'h1);
        for (k = 0; lowSideDrive !== 1'b1 && k < 2000; k++) @(negedge mclk);
        check(32'(k), 32'(DF));
        wait_hs(1'b1);
        for (k = 0; highSideDrive === 1'b1 && k < 2000; k++) @(negedge mclk);
        for (; highSideDrive !== 1'b1 && k < 2000; k++) @(negedge mclk);
        check(32'(k), 32'(PER));
        wait_hs(1'b0);
        for (k = 0; lowSideDrive !== 1'b1 && k < 2000; k++) @(negedge mclk);
        for (k = 0; lowSideDrive === 1'b1 && k < 2000; k++) @(negedge mclk);
        for (k = 0; highSideDrive !== 1'b1 && k < 2000; k++) @(negedge mclk);
        check(32'(k), 32'(DR));
    endtask

    // Current sits above the threshold: only blanking lets the pulse start.
    task automatic t_blank;
        floorLevel = 12'hfff;
        slope = 12'h0;
        on_width;
        check(32'(w >= C3 - C4 - DR - 1 && w <= C3 - C4 - DR + 6), 32'h1);
        check(32'(comparatorObservePin), 32'h0);
    endtask

    // A ramping current trips a lowered threshold mid-period.
    task automatic t_peak;
        floorLevel = 12'h0;
        slope = 12'd40;
        saw_load(12'd1000, 12'h0);
        on_width;
        on_width;
        check(32'(w >= 48 && w <= 64), 32'h1);
        repeat (100) @(negedge mclk);
        check(32'(comparatorObservePin), 32'h1);
    endtask

    task automatic t_saw;
        @(posedge mclk);
        cmp2In <= 15'h0064;
        cmp2Write <= 1'b1;
        @(posedge mclk);
        cmp2Write <= 1'b0;
        saw_load(12'd4000, 12'd66);
        repeat (3 * PER) if (thresholdLevel !== 12'd3934) @(negedge mclk);
        next_thr(12'd4000);
        @(posedge mclk);
        filtOut <= 12'd2000;
        filtOutValid <= 1'b1;
        @(posedge mclk);
        filtOutValid <= 1'b0;
        next_thr(12'd3934);
        next_thr(12'd2000);
        next_thr(12'd1934);
    endtask

    task automatic t_conv;
        logic [11:0] sp [2] = '{12'h800, 12'h300};
        logic [11:0] sm [2] = '{12'h300, 12'h800};
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            setpoint <= sp[i];
            adcSample <= sm[i];
            diff = 13'(sp[i]) - 13'(sm[i]);
            repeat (PER + 8) @(negedge mclk);
            repeat (2 * PER) if (filtValid !== 1'b1) @(negedge mclk);
            check(filtData, {16'h0, diff, 3'h0});
            check(32'(adcIrq), 32'h0);
        end
    endtask

    // A stalled sink fills the buffer and holds one result in the sequencer; the trigger after that overruns.
    task automatic t_stall;
        @(posedge mclk);
        filtReady <= 1'b0;
        repeat (5 * PER) @(negedge mclk);
        check(32'({filtValid, resultOverrun}), 32'h3);
        @(posedge mclk);
        filtReady <= 1'b1;
        k = 0;
        repeat (20) begin
            @(negedge mclk);
            if (filtValid === 1'b1) k++;
            if (filtValid === 1'b1) check(filtData, {16'h0, diff, 3'h0});
        end
        check(32'(k >= 2 && k <= 3), 32'h1);
    endtask

    task automatic t_boost;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            {boostHighLevel, boostLowLevel} <= 2'(i);
            repeat (3) @(negedge mclk);
            check(32'({boostHighDrive, boostLowDrive}), 32'(i));
        end
        // With the clock enable low the drives must keep their last levels.
        @(posedge mclk);
        ce <= 1'b0;
        {boostHighLevel, boostLowLevel} <= 2'b00;
        repeat (3) @(negedge mclk);
        check(32'({boostHighDrive, boostLowDrive}), 32'h3);
        @(posedge mclk);
        ce <= 1'b1;
    endtask

    // Both switches on at once would short the supply.
    always @(negedge mclk) begin
        if (nrst === 1'b1) check(32'(highSideDrive & lowSideDrive), 32'h0);
    end

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        {nrst, filtOutValid, sawWrite, cmp2Write, boostHighLevel, boostLowLevel} = '0;
        {ce, filtReady} = 2'b11;
        {adcSample, setpoint, filtOut, sawResetIn, sawStepIn, floorLevel} = '0;
        slope = 12'h1;
        cmp2In = 15'h0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        t_reset;
        @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        t_dead;
        t_blank;
        t_peak;
        t_saw;
        t_conv;
        t_stall;
        t_boost;
        close_out;
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge mclk);
        errCount++;
        close_out;
    end
endmodule
